// ### serial_port_config_consts.svh
`ifndef SERIAL_PORT_CONFIG_CONSTS_SVH
`define SERIAL_PORT_CONFIG_CONSTS_SVH

// Register address space
`define SPC_ADDR_W            12
`define SPC_ADDR_PORT_CFG     12'h000
`define SPC_ADDR_PART_IDENTIFIER      12'h003
`define SPC_ADDR_READBACK     12'h004
`define SPC_ADDR_TAG_LOW      12'h005
`define SPC_ADDR_TAG_HIGH     12'h006
`define SPC_ADDR_STEP         12'h001

// Field positions in the port configuration and readback registers
`define SPC_BIT_FOUR_WIRE     7
`define SPC_BIT_LSB_FIRST     6
`define SPC_BIT_SOFT_RESET    5
`define SPC_BIT_READBACK_ACT  0

// Byte and bit counting
`define SPC_BYTE_W            8
`define SPC_BIT_CNT_W         3
`define SPC_BIT_CNT_STEP      3'h1
`define SPC_BIT_CNT_LAST      3'h7
`define SPC_BYTE_ZERO         8'h00
`define SPC_RB_UNUSED_ZERO    7'h00
`define SPC_TAG_W             16
`define SPC_TAG_RESET         16'h0000

// Arbitrary neutral identifier value
`define SPC_PART_IDENTIFIER_DEFAULT   8'h5a

`endif

// ### serial_port_config_pkg.sv
`include "serial_port_config_consts.svh"

package serial_port_config_pkg;

    typedef enum logic [3:0] {
        ST_IDLE     = 4'h1,
        ST_NV_LOAD  = 4'h2,
        ST_DEFAULTS = 4'h4,
        ST_DONE     = 4'h8
    } soft_state_type;

    typedef struct packed {
        soft_state_type                 state;
        logic                           xfer_prev;
        logic                           is_read;
        logic [`SPC_ADDR_W-1:0]         addr;
        logic [`SPC_BIT_CNT_W-1:0]      bit_cnt;
        logic [`SPC_BYTE_W-1:0]         wr_shift;
        logic                           load_pend;
        logic                           four_wire;
        logic                           lsb_first;
        logic                           soft_req;
        logic                           readback_sel;
        logic [`SPC_TAG_W-1:0]          tag_buf;
        logic [`SPC_TAG_W-1:0]          tag_act;
        logic                           ext_wr_en;
        logic [`SPC_ADDR_W-1:0]         ext_wr_addr;
        logic [`SPC_BYTE_W-1:0]         ext_wr_data;
        logic                           soft_defaults;
    } regs_type;

    typedef struct packed {
        logic [`SPC_BYTE_W-1:0]         data;
        logic                           drive_bit;
    } shift_regs_type;

endpackage : serial_port_config_pkg

// ### serial_pin_driver.sv
`include "serial_port_config_consts.svh"

module serial_pin_driver (
    input  wire logic                    sys_clk_i,
    input  wire logic                    rst_n_i,
    input  wire logic                    load_i,
    input  wire logic [`SPC_BYTE_W-1:0]  load_data_i,
    input  wire logic                    shift_i,
    input  wire logic                    lsb_first_i,
    input  wire logic                    four_wire_i,
    input  wire logic                    read_active_i,
    output logic                         sdio_o,
    output logic                         sdio_oe_o,
    output logic                         serial_data_out_pin_o,
    output logic                         serial_data_out_pin_oe_o
);

    serial_port_config_pkg::shift_regs_type sh_reg;
    serial_port_config_pkg::shift_regs_type sh_next;
    logic [`SPC_BYTE_W-1:0]                 shifted;

    always_comb begin
        sh_next = sh_reg;
        shifted = sh_reg.data;
        if (load_i) begin
            sh_next.data      = load_data_i;
            sh_next.drive_bit = lsb_first_i ? load_data_i[0] : load_data_i[`SPC_BYTE_W-1];
        end else if (shift_i) begin
            if (lsb_first_i) begin
                shifted = {1'b0, sh_reg.data[`SPC_BYTE_W-1:1]};
            end else begin
                shifted = {sh_reg.data[`SPC_BYTE_W-2:0], 1'b0};
            end
            sh_next.data      = shifted;
            sh_next.drive_bit = lsb_first_i ? shifted[0] : shifted[`SPC_BYTE_W-1];
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sh_reg <= '0;
        end else begin
            sh_reg <= sh_next;
        end
    end

    assign sdio_o                   = sh_reg.drive_bit;
    assign sdio_oe_o                = read_active_i & ~four_wire_i;
    assign serial_data_out_pin_o    = sh_reg.drive_bit;
    assign serial_data_out_pin_oe_o = read_active_i & four_wire_i;

endmodule : serial_pin_driver

// ### serial_port_config_regs.sv
// Notes on behaviour
// - Direction bit clear: data pin reads and writes, separate output pin undriven.
// - Direction bit set outside I2C mode: reads leave on the output pin, writes enter the data pin.
// - Order bit clear: most significant bit first, address decrements per byte.
// - Order bit set: least significant bit first, address increments per byte.
// - In I2C mode the order and address direction bit has no effect.
// - Writing one to the soft reset bit starts it; hardware clears it when done.
// - Soft reset with load select high reloads registers from nonvolatile storage.
// - Soft reset with load select low returns registers to on-chip defaults.
// - Read-only part identifier; writes to it are ignored.
// - Readback select clear: reads return buffer copies of registers.
// - Readback select set: reads return active registers.
// - Sixteen-bit version tag, low byte then high byte, host writable.
// - Version tag resets to zero and steers nothing else.
`include "serial_port_config_consts.svh"

module serial_port_config_regs #(
    parameter logic [`SPC_BYTE_W-1:0] PART_IDENTIFIER = `SPC_PART_IDENTIFIER_DEFAULT
) (
    input  wire logic                    sys_clk_i,
    input  wire logic                    rst_n_i,
    input  wire logic                    i2c_mode_i,
    input  wire logic                    nv_load_select_i,
    input  wire logic                    xfer_active_i,
    input  wire logic                    xfer_read_i,
    input  wire logic [`SPC_ADDR_W-1:0]  xfer_addr_i,
    input  wire logic                    bit_strobe_i,
    input  wire logic                    sdio_i,
    input  wire logic                    io_update_i,
    input  wire logic                    nv_wr_en_i,
    input  wire logic [`SPC_ADDR_W-1:0]  nv_wr_addr_i,
    input  wire logic [`SPC_BYTE_W-1:0]  nv_wr_data_i,
    input  wire logic                    nv_load_done_i,
    input  wire logic [`SPC_BYTE_W-1:0]  ext_rd_data_i,
    output logic                         sdio_o,
    output logic                         sdio_oe_o,
    output logic                         serial_data_out_pin_o,
    output logic                         serial_data_out_pin_oe_o,
    output logic                         four_wire_select_o,
    output logic                         lsb_first_o,
    output logic                         readback_active_o,
    output logic                         soft_reset_busy_o,
    output logic                         nv_load_req_o,
    output logic                         soft_defaults_o,
    output logic                         ext_wr_en_o,
    output logic [`SPC_ADDR_W-1:0]       ext_wr_addr_o,
    output logic [`SPC_BYTE_W-1:0]       ext_wr_data_o,
    output logic [`SPC_ADDR_W-1:0]       cur_addr_o
);

    localparam serial_port_config_pkg::regs_type REGS_RESET = '{
        state:   serial_port_config_pkg::ST_IDLE,
        default: '0
    };

    serial_port_config_pkg::regs_type regs_reg;
    serial_port_config_pkg::regs_type regs_next;

    logic                    eff_lsb;
    logic                    addr_incr;
    logic                    wr_hit;
    logic                    wr_from_nv;
    logic                    soft_set;
    logic [`SPC_ADDR_W-1:0]  wr_addr;
    logic [`SPC_BYTE_W-1:0]  wr_data;
    logic [`SPC_BYTE_W-1:0]  rd_byte;
    logic                    xfer_begin;
    logic                    shift_strobe;
    logic                    read_active;

    assign eff_lsb      = regs_reg.lsb_first & ~i2c_mode_i;
    assign addr_incr    = eff_lsb | i2c_mode_i;
    assign xfer_begin   = xfer_active_i & ~regs_reg.xfer_prev;
    assign shift_strobe = xfer_active_i & ~xfer_begin & bit_strobe_i & regs_reg.is_read;
    // Direction is unknown until the start edge latches it; never drive before then
    assign read_active  = xfer_active_i & ~xfer_begin & regs_reg.is_read;

    // Readback mux, selected by the current transfer address
    always_comb begin
        rd_byte = `SPC_BYTE_ZERO;
        case (regs_reg.addr)
            `SPC_ADDR_PORT_CFG: begin
                // Low nibble mirrors the high nibble; bit 4 and its mirror read zero
                rd_byte[`SPC_BIT_FOUR_WIRE]  = regs_reg.four_wire & ~i2c_mode_i;
                rd_byte[`SPC_BIT_LSB_FIRST]  = regs_reg.lsb_first & ~i2c_mode_i;
                rd_byte[`SPC_BIT_SOFT_RESET] = regs_reg.soft_req;
                rd_byte[2]                   = regs_reg.soft_req;
                rd_byte[1]                   = regs_reg.lsb_first & ~i2c_mode_i;
                rd_byte[0]                   = regs_reg.four_wire & ~i2c_mode_i;
            end
            `SPC_ADDR_PART_IDENTIFIER: begin
                rd_byte = PART_IDENTIFIER;
            end
            `SPC_ADDR_READBACK: begin
                rd_byte = {`SPC_RB_UNUSED_ZERO, regs_reg.readback_sel};
            end
            `SPC_ADDR_TAG_LOW: begin
                rd_byte = regs_reg.readback_sel ? regs_reg.tag_act[7:0]
                                                : regs_reg.tag_buf[7:0];
            end
            `SPC_ADDR_TAG_HIGH: begin
                rd_byte = regs_reg.readback_sel ? regs_reg.tag_act[15:8]
                                                : regs_reg.tag_buf[15:8];
            end
            default: begin
                rd_byte = ext_rd_data_i;
            end
        endcase
    end

    always_comb begin
        regs_next               = regs_reg;
        regs_next.ext_wr_en     = 1'b0;
        regs_next.soft_defaults = 1'b0;
        regs_next.load_pend     = 1'b0;
        regs_next.xfer_prev     = xfer_active_i;
        wr_hit                  = 1'b0;
        wr_from_nv              = 1'b0;
        soft_set                = 1'b0;
        wr_addr                 = regs_reg.addr;
        wr_data                 = `SPC_BYTE_ZERO;

        // Serial byte assembly and address sequencing
        if (xfer_begin) begin
            regs_next.addr      = xfer_addr_i;
            regs_next.bit_cnt   = '0;
            regs_next.is_read   = xfer_read_i;
            regs_next.load_pend = xfer_read_i;
        end else if (xfer_active_i && bit_strobe_i) begin
            if (!regs_reg.is_read) begin
                if (eff_lsb) begin
                    regs_next.wr_shift = {sdio_i, regs_reg.wr_shift[`SPC_BYTE_W-1:1]};
                end else begin
                    regs_next.wr_shift = {regs_reg.wr_shift[`SPC_BYTE_W-2:0], sdio_i};
                end
            end
            regs_next.bit_cnt = regs_reg.bit_cnt + `SPC_BIT_CNT_STEP;
            if (regs_reg.bit_cnt == `SPC_BIT_CNT_LAST) begin
                if (addr_incr) begin
                    regs_next.addr = regs_reg.addr + `SPC_ADDR_STEP;
                end else begin
                    regs_next.addr = regs_reg.addr - `SPC_ADDR_STEP;
                end
                regs_next.load_pend = regs_reg.is_read;
                if (!regs_reg.is_read) begin
                    wr_hit  = 1'b1;
                    wr_addr = regs_reg.addr;
                    wr_data = regs_next.wr_shift;
                end
            end
        end

        // Nonvolatile reload takes the write path while it runs
        if (regs_reg.state == serial_port_config_pkg::ST_NV_LOAD && nv_wr_en_i) begin
            wr_hit     = 1'b1;
            wr_from_nv = 1'b1;
            wr_addr    = nv_wr_addr_i;
            wr_data    = nv_wr_data_i;
        end

        if (wr_hit) begin
            case (wr_addr)
                `SPC_ADDR_PORT_CFG: begin
                    // Low nibble is only a mirror and is not stored
                    regs_next.four_wire = wr_data[`SPC_BIT_FOUR_WIRE];
                    regs_next.lsb_first = wr_data[`SPC_BIT_LSB_FIRST];
                    if (!wr_from_nv && wr_data[`SPC_BIT_SOFT_RESET]) begin
                        soft_set           = 1'b1;
                        regs_next.soft_req = 1'b1;
                    end
                end
                `SPC_ADDR_PART_IDENTIFIER: begin
                    regs_next.ext_wr_en = 1'b0;
                end
                `SPC_ADDR_READBACK: begin
                    regs_next.readback_sel = wr_data[`SPC_BIT_READBACK_ACT];
                end
                `SPC_ADDR_TAG_LOW: begin
                    regs_next.tag_buf[7:0] = wr_data;
                    if (wr_from_nv) begin
                        regs_next.tag_act[7:0] = wr_data;
                    end
                end
                `SPC_ADDR_TAG_HIGH: begin
                    regs_next.tag_buf[15:8] = wr_data;
                    if (wr_from_nv) begin
                        regs_next.tag_act[15:8] = wr_data;
                    end
                end
                default: begin
                    regs_next.ext_wr_en   = 1'b1;
                    regs_next.ext_wr_addr = wr_addr;
                    regs_next.ext_wr_data = wr_data;
                end
            endcase
        end

        // Buffer to active transfer
        if (io_update_i) begin
            regs_next.tag_act = regs_next.tag_buf;
        end

        // Soft reset sequence
        case (regs_reg.state)
            serial_port_config_pkg::ST_IDLE: begin
                if (regs_reg.soft_req) begin
                    if (nv_load_select_i) begin
                        regs_next.state = serial_port_config_pkg::ST_NV_LOAD;
                    end else begin
                        regs_next.state = serial_port_config_pkg::ST_DEFAULTS;
                    end
                end
            end
            serial_port_config_pkg::ST_NV_LOAD: begin
                if (nv_load_done_i) begin
                    regs_next.state = serial_port_config_pkg::ST_DONE;
                end
            end
            serial_port_config_pkg::ST_DEFAULTS: begin
                regs_next.four_wire     = 1'b0;
                regs_next.lsb_first     = 1'b0;
                regs_next.readback_sel  = 1'b0;
                regs_next.tag_buf       = `SPC_TAG_RESET;
                regs_next.tag_act       = `SPC_TAG_RESET;
                regs_next.soft_defaults = 1'b1;
                regs_next.state         = serial_port_config_pkg::ST_DONE;
            end
            serial_port_config_pkg::ST_DONE: begin
                // A new request landing now survives the self-clear
                regs_next.soft_req = soft_set;
                regs_next.state    = serial_port_config_pkg::ST_IDLE;
            end
            default: begin
                regs_next.state = serial_port_config_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            regs_reg <= REGS_RESET;
        end else begin
            regs_reg <= regs_next;
        end
    end

    serial_pin_driver u_pin_driver (
        .sys_clk_i                (sys_clk_i),
        .rst_n_i                  (rst_n_i),
        .load_i                   (regs_reg.load_pend),
        .load_data_i              (rd_byte),
        .shift_i                  (shift_strobe),
        .lsb_first_i              (eff_lsb),
        .four_wire_i              (four_wire_select_o),
        .read_active_i            (read_active),
        .sdio_o                   (sdio_o),
        .sdio_oe_o                (sdio_oe_o),
        .serial_data_out_pin_o    (serial_data_out_pin_o),
        .serial_data_out_pin_oe_o (serial_data_out_pin_oe_o)
    );

    assign four_wire_select_o = regs_reg.four_wire & ~i2c_mode_i;
    assign lsb_first_o        = eff_lsb;
    assign readback_active_o  = regs_reg.readback_sel;
    assign soft_reset_busy_o  = regs_reg.soft_req;
    assign nv_load_req_o      = (regs_reg.state == serial_port_config_pkg::ST_NV_LOAD);
    assign soft_defaults_o    = regs_reg.soft_defaults;
    assign ext_wr_en_o        = regs_reg.ext_wr_en;
    assign ext_wr_addr_o      = regs_reg.ext_wr_addr;
    assign ext_wr_data_o      = regs_reg.ext_wr_data;
    assign cur_addr_o         = regs_reg.addr;

endmodule : serial_port_config_regs

// ### serial_port_config_asserts.sv
`include "serial_port_config_consts.svh"

module serial_port_config_asserts (
    input  wire logic                   sys_clk_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   i2c_mode_i,
    input  wire logic                   nv_load_select_i,
    input  wire logic                   xfer_active_i,
    input  wire logic                   sdio_oe_o,
    input  wire logic                   serial_data_out_pin_oe_o,
    input  wire logic                   four_wire_select_o,
    input  wire logic                   lsb_first_o,
    input  wire logic                   readback_active_o,
    input  wire logic                   soft_reset_busy_o,
    input  wire logic                   nv_load_req_o,
    input  wire logic                   soft_defaults_o,
    input  wire logic                   ext_wr_en_o,
    input  wire logic [`SPC_ADDR_W-1:0] ext_wr_addr_o,
    input  wire logic [`SPC_ADDR_W-1:0] cur_addr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence reset_start;
        $rose(soft_reset_busy_o);
    endsequence
    // Address moved between bytes of one SPI transfer
    sequence addr_step;
        xfer_active_i && $past(xfer_active_i) && $past(xfer_active_i, 2)
            && $changed(cur_addr_o) && !$past(i2c_mode_i);
    endsequence

    chk_three_wire_pin: assert property (!four_wire_select_o |-> !serial_data_out_pin_oe_o)
        else $error("output pin driven in three-wire mode");
    chk_four_wire_pin: assert property (four_wire_select_o |-> !sdio_oe_o)
        else $error("data pin driven in four-wire mode");
    chk_idle_no_drive: assert property (!xfer_active_i && !$past(xfer_active_i)
        |-> !sdio_oe_o && !serial_data_out_pin_oe_o)
        else $error("pin driven outside a transfer");
    chk_msb_addr_down: assert property (addr_step ##0 !$past(lsb_first_o)
        |-> cur_addr_o == $past(cur_addr_o) - `SPC_ADDR_STEP)
        else $error("address did not decrement");
    chk_lsb_addr_up: assert property (addr_step ##0 $past(lsb_first_o)
        |-> cur_addr_o == $past(cur_addr_o) + `SPC_ADDR_STEP)
        else $error("address did not increment");
    chk_i2c_order_fixed: assert property (i2c_mode_i && $past(i2c_mode_i)
        |-> !lsb_first_o && !four_wire_select_o)
        else $error("order bit active in i2c mode");
    chk_defaults_path: assert property (reset_start ##0 !nv_load_select_i
        |-> ##[0:3] soft_defaults_o)
        else $error("defaults pulse missing");
    chk_nv_path: assert property (reset_start ##0 nv_load_select_i |-> ##[0:3] nv_load_req_o)
        else $error("reload request missing");
    chk_busy_ends: assert property (soft_defaults_o |-> ##[0:3] !soft_reset_busy_o)
        else $error("soft reset bit not cleared");
    chk_defaults_clear: assert property (soft_defaults_o
        |-> ##[0:2] (!four_wire_select_o && !lsb_first_o && !readback_active_o))
        else $error("settings not returned to defaults");
    chk_ext_addr_range: assert property (ext_wr_en_o |-> !(ext_wr_addr_o inside
        {`SPC_ADDR_PORT_CFG, `SPC_ADDR_PART_IDENTIFIER, `SPC_ADDR_READBACK, `SPC_ADDR_TAG_LOW,
        `SPC_ADDR_TAG_HIGH}))
        else $error("local register write forwarded");
endmodule : serial_port_config_asserts

bind serial_port_config_regs serial_port_config_asserts u_asserts (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .i2c_mode_i(i2c_mode_i),
    .nv_load_select_i(nv_load_select_i), .xfer_active_i(xfer_active_i),
    .sdio_oe_o(sdio_oe_o), .serial_data_out_pin_oe_o(serial_data_out_pin_oe_o),
    .four_wire_select_o(four_wire_select_o), .lsb_first_o(lsb_first_o),
    .readback_active_o(readback_active_o), .soft_reset_busy_o(soft_reset_busy_o),
    .nv_load_req_o(nv_load_req_o), .soft_defaults_o(soft_defaults_o),
    .ext_wr_en_o(ext_wr_en_o), .ext_wr_addr_o(ext_wr_addr_o), .cur_addr_o(cur_addr_o)
);

// ### serial_host_model.sv
`include "serial_port_config_consts.svh"

module serial_host_model (
    input  wire logic                   sys_clk_i,
    input  wire logic                   lsb_first_i,
    input  wire logic                   four_wire_i,
    input  wire logic                   sdio_i,
    input  wire logic                   sdo_i,
    output logic                        xfer_active_o = 1'b0,
    output logic                        xfer_read_o = 1'b0,
    output logic [`SPC_ADDR_W-1:0]      xfer_addr_o = '0,
    output logic                        bit_strobe_o = 1'b0,
    output logic                        sdio_o = 1'b0,
    output logic                        rd_valid_o = 1'b0,
    output logic [7:0]                  rd_data_o = 8'h00
);
    timeunit 1ns;
    timeprecision 1ps;

    task automatic write(input logic [`SPC_ADDR_W-1:0] a, input logic [15:0] d, input int n);
        @(posedge sys_clk_i) #1;
        xfer_active_o = 1'b1;
        xfer_read_o = 1'b0;
        xfer_addr_o = a;
        for (int i = 0; i < 8 * n; i++) begin
            @(posedge sys_clk_i) #1;
            bit_strobe_o = 1'b1;
            sdio_o = d[(i / 8) * 8 + (lsb_first_i ? i % 8 : 7 - i % 8)];
        end
        @(posedge sys_clk_i) #1;
        xfer_active_o = 1'b0;
        bit_strobe_o = 1'b0;
        sdio_o = ~sdio_o;
        repeat (2) @(posedge sys_clk_i);
        #1;
    endtask : write

    // Strobes four cycles apart leave room for the byte load
    task automatic read(input logic [`SPC_ADDR_W-1:0] a);
        @(posedge sys_clk_i) #1;
        xfer_active_o = 1'b1;
        xfer_read_o = 1'b1;
        xfer_addr_o = a;
        for (int i = 0; i < 8; i++) begin
            repeat (3) @(posedge sys_clk_i);
            #1;
            rd_data_o[lsb_first_i ? i : 7 - i] = four_wire_i ? sdo_i : sdio_i;
            bit_strobe_o = 1'b1;
            @(posedge sys_clk_i) #1;
            bit_strobe_o = 1'b0;
        end
        xfer_active_o = 1'b0;
        rd_valid_o = 1'b1;
        @(posedge sys_clk_i) #1;
        rd_valid_o = 1'b0;
        repeat (2) @(posedge sys_clk_i);
        #1;
    endtask : read
endmodule : serial_host_model

// ### serial_port_config_regs_test.sv
`include "serial_port_config_consts.svh"

module serial_port_config_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] ID = 8'h3c;  // Arbitrary identifier

    logic                   clk = 1'b0;
    logic                   rst_n, i2c, nv_sel, io_upd, nv_en, nv_done, act, rd, stb, hsdio;
    logic                   rd_valid, d_sdio, d_sdio_oe, serial_data_out_pin, sdo_oe, fw, lsb, busy, nv_req, ew_en;
    logic [`SPC_ADDR_W-1:0] nv_addr, addr, ew_addr, ca;
    logic [7:0]             nv_data, ext_rd, rd_data, ew_data;
    logic                   sdio_w, sdo_w, rb;
    logic [19:0]            ext_q[$], rd_q[$];
    logic [15:0]            t;
    int                     num_errors = 0, n_compared = 0;

    assign sdio_w = d_sdio_oe ? d_sdio : hsdio;
    assign sdo_w = sdo_oe ? serial_data_out_pin : 1'bz;
    always #5 clk = ~clk;

    serial_port_config_regs #(.PART_IDENTIFIER(ID)) dut (
        .sys_clk_i(clk), .rst_n_i(rst_n), .i2c_mode_i(i2c), .nv_load_select_i(nv_sel),
        .xfer_active_i(act), .xfer_read_i(rd), .xfer_addr_i(addr), .bit_strobe_i(stb),
        .sdio_i(sdio_w), .io_update_i(io_upd), .nv_wr_en_i(nv_en), .nv_wr_addr_i(nv_addr),
        .nv_wr_data_i(nv_data), .nv_load_done_i(nv_done), .ext_rd_data_i(ext_rd),
        .sdio_o(d_sdio), .sdio_oe_o(d_sdio_oe), .serial_data_out_pin_o(serial_data_out_pin),
        .serial_data_out_pin_oe_o(sdo_oe), .four_wire_select_o(fw), .lsb_first_o(lsb),
        .readback_active_o(rb), .soft_reset_busy_o(busy), .nv_load_req_o(nv_req),
        .soft_defaults_o(), .ext_wr_en_o(ew_en), .ext_wr_addr_o(ew_addr),
        .ext_wr_data_o(ew_data), .cur_addr_o(ca)
    );
    serial_host_model host (
        .sys_clk_i(clk), .lsb_first_i(lsb), .four_wire_i(fw), .sdio_i(sdio_w), .sdo_i(sdo_w),
        .xfer_active_o(act), .xfer_read_o(rd), .xfer_addr_o(addr), .bit_strobe_o(stb),
        .sdio_o(hsdio), .rd_valid_o(rd_valid), .rd_data_o(rd_data)
    );

    task automatic check(input string nm, input logic [19:0] seen, input logic [19:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error: %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic rdx(input logic [`SPC_ADDR_W-1:0] a, input logic [7:0] e);
        rd_q.push_back({a, e});
        host.read(a);
    endtask : rdx

    task automatic wait_idle;
        for (int i = 0; i < 50 && busy !== 1'b0; i++) @(posedge clk) #1;
        check("busy", busy, 1'b0);
    endtask : wait_idle

    task automatic finish_test;
        if (num_errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test

    always @(posedge clk) begin
        if (ew_en === 1'b1)
            check("ext_write", {ew_addr, ew_data}, ext_q.size() ? ext_q.pop_front() : 20'hx);
        if (rd_valid === 1'b1)
            check("read", {addr, rd_data}, rd_q.size() ? rd_q.pop_front() : 20'hx);
    end

    initial begin
        #50000;
        num_errors++;
        finish_test();
    end

    initial begin
        void'($urandom(16));
        {rst_n, i2c, nv_sel, io_upd, nv_en, nv_done} = '0;
        nv_addr = '0;
        nv_data = 8'h00;
        ext_rd = 8'($urandom());
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        for (int a = 0; a < 7; a++)
            rdx(12'(a), a == 3 ? ID : (a == 1 || a == 2) ? ext_rd : 8'h00);
        t = 16'($urandom());
        host.write(`SPC_ADDR_PART_IDENTIFIER, t, 1);
        rdx(`SPC_ADDR_PART_IDENTIFIER, ID);
        ext_q.push_back({12'h001, t[7:0]});
        host.write(12'h001, t, 1);
        host.write(`SPC_ADDR_TAG_HIGH, {t[7:0], t[15:8]}, 2);
        check("cur_addr", ca, 12'h004);
        rdx(`SPC_ADDR_TAG_LOW, t[7:0]);
        rdx(`SPC_ADDR_TAG_HIGH, t[15:8]);
        host.write(`SPC_ADDR_READBACK, 16'h00ff, 1);
        check("readback_active", rb, 1'b1);
        rdx(`SPC_ADDR_READBACK, 8'h01);
        rdx(`SPC_ADDR_TAG_LOW, 8'h00);
        @(posedge clk) #1 io_upd = 1'b1;
        @(posedge clk) #1 io_upd = 1'b0;
        rdx(`SPC_ADDR_TAG_HIGH, t[15:8]);
        host.write(`SPC_ADDR_READBACK, 16'h0000, 1);
        check("readback_active", rb, 1'b0);
        host.write(`SPC_ADDR_PORT_CFG, 16'h0042, 1);
        check("lsb_first", lsb, 1'b1);
        rdx(`SPC_ADDR_PORT_CFG, 8'h42);
        t = 16'($urandom());
        host.write(`SPC_ADDR_TAG_LOW, t, 2);
        check("cur_addr", ca, 12'h007);
        rdx(`SPC_ADDR_TAG_HIGH, t[15:8]);
        i2c = 1'b1;
        @(posedge clk) #1 check("i2c_order", lsb, 1'b0);
        rdx(`SPC_ADDR_TAG_LOW, t[7:0]);
        i2c = 1'b0;
        host.write(`SPC_ADDR_PORT_CFG, 16'h0081, 1);
        rdx(`SPC_ADDR_TAG_LOW, t[7:0]);
        check("four_wire", fw, 1'b1);
        host.write(`SPC_ADDR_PORT_CFG, 16'h00a5, 1);
        wait_idle();
        rdx(`SPC_ADDR_TAG_LOW, 8'h00);
        rdx(`SPC_ADDR_PORT_CFG, 8'h00);
        nv_sel = 1'b1;
        host.write(`SPC_ADDR_PORT_CFG, 16'h0024, 1);
        for (int i = 0; i < 50 && nv_req !== 1'b1; i++) @(posedge clk) #1;
        check("nv_request", nv_req, 1'b1);
        {nv_en, nv_addr, nv_data} = {1'b1, `SPC_ADDR_TAG_LOW, t[15:8]};
        @(posedge clk) #1 nv_en = 1'b0;
        nv_done = 1'b1;
        @(posedge clk) #1 nv_done = 1'b0;
        wait_idle();
        rdx(`SPC_ADDR_TAG_LOW, t[15:8]);
        nv_sel = 1'b0;
        check("pending", 20'(rd_q.size() + ext_q.size()), 20'h0_0000);
        finish_test();
    end
endmodule : serial_port_config_regs_test
